// ==== hw/cpw_pkg.sv ====
/*
 Package for the capture, compare and PWM unit: register map, mode
 codes, field positions, reset values and the register bus carrier.
 Assumes an 8-bit register port and timers that live outside the unit.
*/
package cpw_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned WORD_W = 16;

  // Register indices on the plain port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_LOW  = 2'h1;
  localparam logic [1:0] ADDR_HIGH = 2'h2;
  localparam logic [1:0] ADDR_STAT = 2'h3;

  // Control register field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_DUTY_LSB = 4;
  // Status register bit positions
  localparam int unsigned STAT_FLAG_BIT = 0;
  localparam int unsigned STAT_PIN_BIT  = 1;

  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4TH  = 4'h6;
  localparam logic [3:0] MODE_CAP_16TH = 4'h7;
  localparam logic [3:0] MODE_CMP_SET  = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SWI  = 4'hA;
  localparam logic [3:0] MODE_CMP_SEV  = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP  = 2'h3;
  localparam logic [1:0] MODE_CAP_TOP  = 2'h1;

  localparam logic [3:0] PRE_LAST_4TH  = 4'h3;
  localparam logic [3:0] PRE_LAST_16TH = 4'hF;
  localparam logic [7:0] RST_BYTE      = 8'h00;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpw_bus_req_t;

endpackage : cpw_pkg

// ==== hw/cpw_unit.sv ====
/*
 Capture, compare and PWM unit: all logic of one unit.
 Assumes timer1 and timer2 counters, the port latch and direction bit
 and the converter enable arrive from outside, synchronous to clock_i.
*/
// Behaviour
// R1: Capture copies full timer1 count on event
// R2: Falling, rising, 4th, 16th rising capture events
// R3: Capture sets flag; only software clears it
// R4: Later capture overwrites earlier, no overrun
// R5: Output port latch write can trigger capture
// R6: Timer1 must run synchronous for capture/compare
// R7: Software masks interrupt while changing capture mode
// R8: Prescaler cleared when off, non-capture, reset
// R9: Prescaler switch keeps count; software writes zero
// R10: Compare match drives pin per mode, sets flag
// R11: Zero control write forces output latch low
// R12: Software interrupt mode sets flag, pin unchanged
// R13: Special event resets timer1 pair
// R14: Second unit special event also starts conversion
// R15: Special event reset never sets overflow flag
// R16: PWM period from timer2 period, prescale
// R17: Period roll clears timer2, sets pin, loads duty
// R18: Timer2 postscaler takes no part in PWM
// R19: Duty is low byte plus control bits 5:4
// R20: Duty loads at period end; high byte read-only
// R21: Duty double buffered, cleared on extended match
// R22: Duty beyond period keeps pin constantly high
// R23: Software follows PWM set-up order
// R24: Software sets pin direction per mode
// R25: One compare event per equality occurrence
`timescale 1ns/1ps

module cpw_unit #(
  parameter bit SECOND_UNIT = 1'b0
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  input  wire cpw_pkg::cpw_bus_req_t bus_req_i,
  output logic [cpw_pkg::DATA_W-1:0] rdata_o,
  input  wire logic [cpw_pkg::WORD_W-1:0] timer1_count_i,
  input  wire logic [7:0]            timer2_count_i,
  input  wire logic [7:0]            timer2_period_register_i,
  input  wire logic                  timer2_inc_i,
  input  wire logic [1:0]            timer2_phase_i,
  input  wire logic                  port_latch_i,
  input  wire logic                  port_direction_i,
  input  wire logic                  unit_pin_i,
  input  wire logic                  adc_enable_i,
  output logic                       unit_pin_o,
  output logic                       unit_pin_oe_o,
  output logic                       unit_interrupt_flag_o,
  output logic                       timer1_reset_o,
  output logic                       adc_start_o,
  output logic                       timer2_clear_o
);
  import cpw_pkg::*;

  typedef struct packed {
    logic [3:0]        mode;
    logic [1:0]        duty_lsb;
    logic [7:0]        low;
    logic [7:0]        high;
    logic [1:0]        lat2;
    logic              flag;
    logic              out_latch;
    logic [3:0]        pre_cnt;
    logic              pin_prev;
    logic              match_prev;
    logic [DATA_W-1:0] rdata;
    logic              pin_out;
    logic              pin_oe;
    logic              t1_reset;
    logic              adc_start;
    logic              t2_clear;
  } cpw_state_t;

  cpw_state_t st;
  cpw_state_t next_st;

  logic is_cap;
  logic is_cmp;
  logic is_pwm;
  logic pin_level;
  logic rise;
  logic fall;
  logic cap_event;
  logic match_hit;
  logic roll;
  logic duty_hit;
  logic ctrl_wr;
  logic stat_clr;

  always_comb begin
    is_cap    = (st.mode[3:2] == MODE_CAP_TOP);
    is_pwm    = (st.mode[3:2] == MODE_PWM_TOP);
    is_cmp    = st.mode[3] && !is_pwm;
    // Pin driven as output shows the port latch to the capture logic
    pin_level = port_direction_i ? unit_pin_i : port_latch_i; // [R5]
    rise      = pin_level && !st.pin_prev;
    fall      = !pin_level && st.pin_prev;
    cap_event = 1'b0;
    if (is_cap) begin
      case (st.mode) // [R2]
        MODE_CAP_FALL: cap_event = fall;
        MODE_CAP_RISE: cap_event = rise;
        MODE_CAP_4TH:  cap_event = rise && (st.pre_cnt[1:0] ==
                                            PRE_LAST_4TH[1:0]);
        MODE_CAP_16TH: cap_event = rise && (st.pre_cnt == PRE_LAST_16TH);
        default:       cap_event = 1'b0;
      endcase
    end
    // Edge of equality only, so a stalled timer1 gives one event
    match_hit = is_cmp && (timer1_count_i == {st.high, st.low})
                && !st.match_prev; // [R25]
    // Postscaler is not an input at all; only the raw increment counts
    roll      = is_pwm && timer2_inc_i
                && (timer2_count_i == timer2_period_register_i); // [R17] [R18]
    // Duty beyond the period never meets the count, pin stays high
    duty_hit  = is_pwm && ({st.high, st.lat2} ==
                           {timer2_count_i, timer2_phase_i}); // [R21] [R22]
    ctrl_wr   = bus_req_i.wr && (bus_req_i.addr == ADDR_CTRL);
    stat_clr  = bus_req_i.wr && (bus_req_i.addr == ADDR_STAT)
                && !bus_req_i.wdata[STAT_FLAG_BIT];
  end

  always_comb begin
    next_st            = st;
    next_st.pin_prev   = pin_level;
    next_st.match_prev = is_cmp && (timer1_count_i == {st.high, st.low});
    next_st.t1_reset   = 1'b0;
    next_st.adc_start  = 1'b0;
    next_st.t2_clear   = 1'b0;
    next_st.rdata      = RST_BYTE;

    // Register writes
    if (ctrl_wr) begin
      next_st.mode     = bus_req_i.wdata[CTRL_MODE_LSB +: 4];
      next_st.duty_lsb = bus_req_i.wdata[CTRL_DUTY_LSB +: 2]; // [R19]
    end
    if (bus_req_i.wr && bus_req_i.addr == ADDR_LOW) begin
      next_st.low = bus_req_i.wdata; // [R20]
    end
    // In PWM mode the high byte is loaded by hardware only
    if (bus_req_i.wr && bus_req_i.addr == ADDR_HIGH && !is_pwm) begin
      next_st.high = bus_req_i.wdata; // [R20]
    end
    if (stat_clr) begin
      next_st.flag = 1'b0; // [R3]
    end

    // Prescaler counts rising edges; mode switch inside capture keeps it
    if (!is_cap || ctrl_wr && bus_req_i.wdata[3:2] != MODE_CAP_TOP) begin
      next_st.pre_cnt = '0; // [R8] [R9]
    end else if (rise) begin
      next_st.pre_cnt = st.pre_cnt + 4'h1;
    end

    if (cap_event) begin
      // No overrun flag: last capture simply wins
      {next_st.high, next_st.low} = timer1_count_i; // [R1] [R4]
      next_st.flag = 1'b1; // [R3]
    end

    if (match_hit) begin
      next_st.flag = 1'b1; // [R10] [R12]
      case (st.mode)
        MODE_CMP_SET: next_st.out_latch = 1'b1; // [R10]
        MODE_CMP_CLR: next_st.out_latch = 1'b0; // [R10]
        MODE_CMP_SEV: begin
          // A clear, not an overflow: timer1 flag stays untouched
          next_st.t1_reset  = 1'b1; // [R13] [R15]
          next_st.adc_start = SECOND_UNIT && adc_enable_i; // [R14]
        end
        default: next_st.out_latch = st.out_latch; // [R12]
      endcase
    end

    // PWM: period (period register + 1) x 4 phases x prescale
    if (roll) begin
      next_st.t2_clear  = 1'b1; // [R16] [R17]
      next_st.high      = st.low; // [R17] [R20]
      next_st.lat2      = st.duty_lsb; // [R21]
      next_st.out_latch = ({st.low, st.duty_lsb} != '0); // [R17]
    end else if (duty_hit) begin
      next_st.out_latch = 1'b0; // [R21]
    end

    // Zero write last, so it beats a match or roll in the same cycle
    if (ctrl_wr && bus_req_i.wdata == RST_BYTE) begin
      next_st.out_latch = 1'b0; // [R11]
    end

    // Unit latch owns the pin only in compare and PWM modes
    next_st.pin_out = (is_cmp || is_pwm) ? next_st.out_latch
                                         : port_latch_i;
    next_st.pin_oe  = !port_direction_i;

    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        ADDR_CTRL: next_st.rdata = {2'b00, st.duty_lsb, st.mode};
        ADDR_LOW:  next_st.rdata = st.low;
        ADDR_HIGH: next_st.rdata = st.high;
        ADDR_STAT: next_st.rdata = {6'h00, st.out_latch, st.flag};
        default:   next_st.rdata = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st <= '0; // [R8]
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o               = st.rdata;
  assign unit_pin_o            = st.pin_out;
  assign unit_pin_oe_o         = st.pin_oe;
  assign unit_interrupt_flag_o = st.flag;
  assign timer1_reset_o        = st.t1_reset;
  assign adc_start_o           = st.adc_start;
  assign timer2_clear_o        = st.t2_clear;

  property p_cap_copy;
    @(posedge clock_i) disable iff (!rst_b_i)
    cap_event |=> {st.high, st.low} == $past(timer1_count_i);
  endproperty
  a_cap_copy: assert property (p_cap_copy) // [R1]
    else $error("capture did not copy timer1");

  property p_cap_flag;
    @(posedge clock_i) disable iff (!rst_b_i)
    cap_event |=> unit_interrupt_flag_o;
  endproperty
  a_cap_flag: assert property (p_cap_flag) // [R3]
    else $error("capture did not set flag");

  property p_flag_sticky;
    @(posedge clock_i) disable iff (!rst_b_i)
    st.flag && !stat_clr |=> st.flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // [R3]
    else $error("flag cleared without software");

  property p_pre_clear;
    @(posedge clock_i) disable iff (!rst_b_i)
    !is_cap && !ctrl_wr |=> st.pre_cnt == '0;
  endproperty
  a_pre_clear: assert property (p_pre_clear) // [R8]
    else $error("prescaler not cleared outside capture");

  property p_cmp_set;
    @(posedge clock_i) disable iff (!rst_b_i)
    match_hit && st.mode == MODE_CMP_SET && !ctrl_wr
      |=> st.out_latch ##1 unit_pin_o || port_direction_i;
  endproperty
  a_cmp_set: assert property (p_cmp_set) // [R10]
    else $error("compare set mode did not drive high");

  property p_swi_pin;
    @(posedge clock_i) disable iff (!rst_b_i)
    match_hit && st.mode == MODE_CMP_SWI && !ctrl_wr
      |=> $stable(st.out_latch) && st.flag;
  endproperty
  a_swi_pin: assert property (p_swi_pin) // [R12]
    else $error("software interrupt mode touched pin");

  property p_sev_reset;
    @(posedge clock_i) disable iff (!rst_b_i)
    match_hit && st.mode == MODE_CMP_SEV
      |=> timer1_reset_o ##1 !timer1_reset_o;
  endproperty
  a_sev_reset: assert property (p_sev_reset) // [R13]
    else $error("special event did not reset timer1 once");

  property p_zero_ctrl;
    @(posedge clock_i) disable iff (!rst_b_i)
    ctrl_wr && bus_req_i.wdata == RST_BYTE |=> !st.out_latch;
  endproperty
  a_zero_ctrl: assert property (p_zero_ctrl) // [R11]
    else $error("zero control write left latch high");

  property p_roll;
    @(posedge clock_i) disable iff (!rst_b_i)
    roll |=> timer2_clear_o && st.high == $past(st.low);
  endproperty
  a_roll: assert property (p_roll) // [R17]
    else $error("period roll did not load duty");

  property p_high_ro;
    @(posedge clock_i) disable iff (!rst_b_i)
    is_pwm && !roll && !cap_event |=> st.high == $past(st.high);
  endproperty
  a_high_ro: assert property (p_high_ro) // [R20]
    else $error("active duty changed outside period end");

  property p_one_match;
    @(posedge clock_i) disable iff (!rst_b_i)
    match_hit |=> !match_hit;
  endproperty
  a_one_match: assert property (p_one_match) // [R25]
    else $error("compare match repeated");

  property p_match_flag;
    @(posedge clock_i) disable iff (!rst_b_i)
    match_hit |=> unit_interrupt_flag_o;
  endproperty
  a_match_flag: assert property (p_match_flag) // [R10]
    else $error("compare match did not set flag");

  property p_cmp_clr;
    @(posedge clock_i) disable iff (!rst_b_i)
    match_hit && st.mode == MODE_CMP_CLR |=> !st.out_latch;
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) // [R10]
    else $error("compare clear mode did not drive low");

  property p_adc_gate;
    @(posedge clock_i) disable iff (!rst_b_i)
    match_hit && st.mode == MODE_CMP_SEV
      |=> adc_start_o == (SECOND_UNIT && $past(adc_enable_i));
  endproperty
  a_adc_gate: assert property (p_adc_gate) // [R14]
    else $error("converter start does not follow unit and enable");

  property p_roll_pin;
    @(posedge clock_i) disable iff (!rst_b_i)
    roll && !ctrl_wr
      |=> st.out_latch == ($past({st.low, st.duty_lsb}) != '0);
  endproperty
  a_roll_pin: assert property (p_roll_pin) // [R17]
    else $error("period roll set pin against duty");

  property p_duty_clr;
    @(posedge clock_i) disable iff (!rst_b_i)
    duty_hit && !roll |=> !st.out_latch;
  endproperty
  a_duty_clr: assert property (p_duty_clr) // [R21]
    else $error("duty match did not clear pin");

  property p_pre_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
    is_cap && ctrl_wr && bus_req_i.wdata[3:2] == MODE_CAP_TOP && !rise
      |=> st.pre_cnt == $past(st.pre_cnt);
  endproperty
  a_pre_hold: assert property (p_pre_hold) // [R9]
    else $error("capture mode switch cleared prescaler");

endmodule : cpw_unit

// ==== verif/cpw_pin_src.sv ====
/*
 Pin signal source for the unit bench: bursts of whole pulses.
 Assumes the unit's pin drive and enable come back to form the wire.
*/
`timescale 1ns/1ps
module cpw_pin_src (
  input  wire logic       clock_i,
  input  wire logic       go_i,
  input  wire logic [4:0] count_i,
  input  wire logic       oe_i,
  input  wire logic       drive_i,
  output logic            pin_o,
  output logic            busy_o
);
  logic [6:0] left = 7'h00;
  // Two cycles high, two low, so each edge is seen
  always @(posedge clock_i)
    if (go_i) left <= {count_i, 2'b00};
    else if (left != 7'h00) left <= left - 7'h01;
  assign busy_o = go_i || (left != 7'h00);
  // Unit owns the wire only while its output is enabled
  assign pin_o = oe_i ? drive_i : left[1];
endmodule : cpw_pin_src

// ==== verif/testbench.sv ====
/*
 Self-checking bench for cpw_unit, second unit build.
 Assumes timers, port latch and direction are modelled here.
*/
`timescale 1ns/1ps
module testbench;
  import cpw_pkg::*;
  logic         clock_i, rst_b_i, dir, latch, go, busy, pin_w;
  logic         pin_o, oe, flag, t1rst, adcs, t2clr, mlat, mclr;
  logic         mval, mv2, adc_en;
  logic [1:0]   ph, lat2, lsb;
  logic [3:0]   mm;
  logic [4:0]   cnt;
  logic [7:0]   rdata_o, t2, hi, lo, v, prd;
  logic [15:0]  t1, w;
  cpw_bus_req_t bus;
  int           fail_count, n_tests, seed, k, m, nrst, nadc, r0, a0;
  logic [3:0]   cm [6] = '{4'h8, 4'hA, 4'h9, 4'hB, 4'h8, 4'hB};
  logic         ep [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [9:0]   dt [3] = '{10'h013, 10'h000, 10'h3FF};
  wire          t2inc  = (ph == 2'h3);
  wire          pwm_on = (mm[3:2] == MODE_PWM_TOP);
  wire          roll   = t2inc && (t2 == prd);

  cpw_unit #(.SECOND_UNIT(1'b1)) DUT (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .bus_req_i(bus), .rdata_o(rdata_o), .timer1_count_i(t1),
    .timer2_count_i(t2), .timer2_period_register_i(prd),
    .timer2_inc_i(t2inc), .timer2_phase_i(ph), .port_latch_i(latch),
    .port_direction_i(dir), .unit_pin_i(pin_w), .adc_enable_i(adc_en),
    .unit_pin_o(pin_o), .unit_pin_oe_o(oe), .unit_interrupt_flag_o(flag),
    .timer1_reset_o(t1rst), .adc_start_o(adcs), .timer2_clear_o(t2clr));
  cpw_pin_src SRC (.clock_i(clock_i), .go_i(go), .count_i(cnt),
    .oe_i(oe), .drive_i(pin_o), .pin_o(pin_w), .busy_o(busy));

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic finish_test;
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clock_i);
    bus <= '0;
    @(posedge clock_i);
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i);
    bus <= '0;
    #1 d = rdata_o;
    @(posedge clock_i);
  endtask : rd
  task automatic pulses(input int n);
    cnt <= n[4:0];
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    for (k = 0; k < 200 && busy; k++) @(posedge clock_i);
    if (busy) begin
      fail_count++;
      finish_test();
    end
    repeat (3) @(posedge clock_i);
  endtask : pulses

  // Timer2 with a quarter-cycle phase; timer1 only moves on clock edges
  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      ph <= 2'h0;
      t2 <= 8'h00;
      nrst <= 0;
      nadc <= 0;
    end else begin
      ph <= ph + 2'h1;
      if (t2inc) t2 <= (t2 == prd) ? 8'h00 : t2 + 8'h01;
      nrst <= nrst + int'(t1rst);
      nadc <= nadc + int'(adcs);
    end
  end
  // Reference PWM latch, snooping the register bus
  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      {mclr, mval, mv2, mlat, hi, lat2, lo, lsb, mm} <= '0;
    end else begin
      // Roll only counts in PWM mode, as seen before this edge's write
      mclr <= roll && pwm_on;
      mval <= pwm_on && (mval || roll);
      mv2 <= mval;
      if (roll) begin
        mlat <= ({lo, lsb} != 10'h000);
        hi <= lo;
        lat2 <= lsb;
      end else if ({hi, lat2} == {t2, ph}) mlat <= 1'b0;
      if (bus.wr && bus.addr == ADDR_LOW) lo <= bus.wdata;
      if (bus.wr && bus.addr == ADDR_CTRL) {lsb, mm} <= bus.wdata[5:0];
    end
  end
  always @(negedge clock_i)
    if (pwm_on && rst_b_i) begin
      chk(16'(t2clr), 16'(mclr));
      // Pin register loads with the latch, so no extra cycle of delay
      if (mv2) chk(16'(pin_o), 16'(mlat));
    end

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    {rst_b_i, latch, go, t1, cnt} = '0;
    prd = 8'h05;
    adc_en = 1'b1;
    bus = '0;
    dir = 1'b1;
    seed = 31191;
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    for (m = 4; m < 8; m++) begin
      wr(ADDR_CTRL, 8'(m));
      pulses(2);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CTRL, 8'(m));
      wr(ADDR_STAT, 8'h00);
      t1 <= 16'($random(seed));
      pulses(m == 7 ? 15 : m == 6 ? 3 : 0);
      rd(ADDR_STAT, v);
      chk(16'(v), 16'h0000);
      pulses(1);
      rd(ADDR_STAT, v);
      chk(16'(v), 16'h0001);
      rd(ADDR_LOW, v);
      chk(16'(v), 16'(t1[7:0]));
      rd(ADDR_HIGH, v);
      chk(16'(v), 16'(t1[15:8]));
    end
    pulses(16);
    t1 <= 16'($random(seed));
    pulses(16);
    rd(ADDR_HIGH, v);
    chk(16'(v), 16'(t1[15:8]));
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'(MODE_CAP_RISE));
    dir <= 1'b0;
    wr(ADDR_STAT, 8'h00);
    latch <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd(ADDR_STAT, v);
    chk(16'(v), 16'h0001);
    chk(16'(oe), 16'h0001);
    latch <= 1'b0;
    for (m = 0; m < 6; m++) begin
      w = 16'($random(seed));
      t1 <= ~w;
      wr(ADDR_LOW, w[7:0]);
      wr(ADDR_HIGH, w[15:8]);
      wr(ADDR_CTRL, {4'h0, cm[m]});
      adc_en <= (m != 5);
      wr(ADDR_STAT, 8'h00);
      r0 = nrst;
      a0 = nadc;
      t1 <= w;
      repeat (5) @(posedge clock_i);
      t1 <= ~w;
      rd(ADDR_STAT, v);
      chk(16'(v), 16'({ep[m], 1'b1}));
      chk(16'(pin_o), 16'(ep[m]));
      chk(16'(flag), 16'h0001);
      chk(16'(nrst - r0), 16'(cm[m] == MODE_CMP_SEV));
      chk(16'(nadc - a0), 16'(cm[m] == MODE_CMP_SEV && m != 5));
    end
    latch <= 1'b1;
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_STAT, v);
    chk(16'(v), 16'h0001);
    chk(16'(pin_o), 16'h0001);
    latch <= 1'b0;
    // Set-up order: period, duty low byte, then duty bits with mode
    for (m = 0; m < 3; m++) begin
      // Period only grows, so timer2 never has to wrap past the top
      prd <= 8'h05 + 8'(m);
      wr(ADDR_LOW, dt[m][9:2]);
      wr(ADDR_CTRL, {2'b00, dt[m][1:0], 4'hC});
      repeat (70) @(posedge clock_i);
      wr(ADDR_HIGH, ~dt[m][9:2]);
      rd(ADDR_HIGH, v);
      chk(16'(v), 16'(dt[m][9:2]));
    end
    finish_test();
  end
endmodule : testbench
